// *** core/cpb_bridge.sv ***
// Purpose: forwards host I/O reads and writes to two port buses
// Assumes: one queue entry per port; host retries if not acked
// Notes: port index 0 is the first port bus, 1 the second
`include "cpb_defines.svh"
module cpb_bridge (
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	input wire logic I_HB_ADDR_VALID,
	input wire cpb_pkg::cpb_op_t I_HB_OP,
	input wire logic [31:0] I_HB_ADDR,
	input wire logic I_HB_ADDR_PAR,
	input wire logic [7:0] I_HB_MASK,
	input wire logic I_HB_DATA_VALID,
	input wire logic [63:0] I_HB_DATA,
	input wire logic I_HB_DATA_PAR,
	output logic O_HB_ACK,
	output logic O_SOFT_ERR_REQ,
	output logic O_BUS_PAR_ERR,
	input wire logic I_BUS_PAR_ERR_CLR,
	output logic O_RR_REQ,
	input wire logic I_RR_GNT,
	output logic O_RR_VALID,
	output logic [1:0] O_RR_TAG,
	output logic [63:0] O_RR_DATA,
	output logic [1:0] O_PB_REQ,
	input wire logic [1:0] I_PB_GNT,
	output logic [1:0] O_PB_WR,
	output logic [1:0] O_PB_ISTREAM,
	output logic [1:0][31:0] O_PB_ADDR,
	output logic [1:0][31:0] O_PB_WDATA,
	output logic [1:0][3:0] O_PB_BE,
	output logic [1:0] O_PB_PREF_INV,
	input wire logic [1:0] I_PB_RDATA_VALID,
	input wire logic [1:0][31:0] I_PB_RDATA,
	input wire logic [1:0] I_PB_TIMEOUT
);
	import cpb_pkg::*;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// even parity: data bits plus parity bit xor to zero
	function automatic logic par_ok(input logic [63:0] d, input logic p);
		par_ok = ~(^{d, p});
	endfunction

	function automatic logic [1:0] port_hit(input logic [31:0] a);
		if ((a & `CPB_PORT_SEL_MASK) == `CPB_PORT0_BASE) begin
			port_hit = 2'b01;
		end else if ((a & `CPB_PORT_SEL_MASK) == `CPB_PORT1_BASE) begin
			port_hit = 2'b10;
		end else begin
			port_hit = 2'b00;
		end
	endfunction

	// lower longword goes first unless its masks are all zero
	function automatic logic first_hi(input logic [7:0] m);
		first_hi = (m[3:0] == 4'h0);
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic addr_ok;
	logic [1:0] hit;
	logic tgt;
	logic is_wr;
	logic ack;
	logic addr_err;
	logic data_ok;
	logic wd_pend_ff;
	logic wd_port_ff;
	logic soft_err_ff;
	logic par_err_ff;
	logic [1:0] q_alloc_ff;
	logic [1:0] q_vld_ff;
	logic [1:0] q_wr_ff;
	logic [1:0] q_ist_ff;
	logic [1:0][31:0] q_addr_ff;
	logic [1:0][7:0] q_mask_ff;
	logic [1:0][63:0] q_data_ff;
	cpb_pst_t pst_ff [2];
	logic [1:0] cur_hi_ff;
	logic [1:0] pref_inv_ff;
	logic [1:0] more;
	logic [1:0] port_done;
	logic [1:0] load_en;
	logic [1:0] load_hi;
	logic [1:0] buf_we;
	logic [1:0] fill_done;
	logic [1:0] rr_full_ff;
	logic [1:0][1:0] rr_tag_ff;
	cpb_rst_t rs_ff;
	logic rr_sel_ff;
	logic rr_take;
	logic rr_pick;
	logic [1:0][31:0] out_addr_ff;
	logic [1:0][31:0] out_wdata_ff;
	logic [1:0][3:0] out_be_ff;
	logic [1:0] out_wr_ff;
	logic [1:0] out_ist_ff;
	logic [1:0] tag_out_ff;
	logic [63:0] rd_data;

	// ----------------------------------------
	// host slave decode
	// ----------------------------------------
	assign addr_ok = par_ok({32'h0000_0000, I_HB_ADDR}, I_HB_ADDR_PAR);
	assign hit = port_hit(I_HB_ADDR);
	assign tgt = hit[1];
	assign is_wr = (I_HB_OP == CPB_OP_WRITE) || (I_HB_OP == CPB_OP_WRITE_REL);
	// a busy entry withholds the ack; the host must retry later
	assign ack = I_HB_ADDR_VALID && addr_ok && (hit != 2'b00) && !q_alloc_ff[tgt]
		&& !wd_pend_ff;
	assign addr_err = I_HB_ADDR_VALID && !addr_ok;
	assign data_ok = I_HB_DATA_VALID && par_ok(I_HB_DATA, I_HB_DATA_PAR);
	assign O_HB_ACK = ack;
	assign O_SOFT_ERR_REQ = soft_err_ff;
	assign O_BUS_PAR_ERR = par_err_ff;

	// write data is taken only in the cycle after the ack
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			wd_pend_ff <= 1'b0;
			wd_port_ff <= 1'b0;
		end else begin
			wd_pend_ff <= ack && is_wr;
			wd_port_ff <= tgt;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			soft_err_ff <= 1'b0;
		end else begin
			soft_err_ff <= addr_err || (wd_pend_ff && !data_ok);
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			par_err_ff <= 1'b0;
		end else if (addr_err) begin
			par_err_ff <= 1'b1;
		end else if (I_BUS_PAR_ERR_CLR) begin
			par_err_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// request queue, one entry per port
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			q_alloc_ff <= 2'b00;
			q_vld_ff <= 2'b00;
			q_wr_ff <= 2'b00;
			q_ist_ff <= 2'b00;
			q_addr_ff <= '{default: `CPB_RST_ADDR};
			q_mask_ff <= '{default: `CPB_RST_MASK};
			q_data_ff <= '{default: `CPB_RST_DATA};
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (ack && (tgt == p[0])) begin
					q_alloc_ff[p] <= 1'b1;
					q_vld_ff[p] <= !is_wr;
					q_wr_ff[p] <= is_wr;
					q_ist_ff[p] <= (I_HB_OP == CPB_OP_INSTRUCTION_READ_OP);
					q_addr_ff[p] <= I_HB_ADDR;
					q_mask_ff[p] <= I_HB_MASK;
				end else if (wd_pend_ff && (wd_port_ff == p[0])) begin
					if (data_ok) begin
						q_data_ff[p] <= I_HB_DATA;
						q_vld_ff[p] <= 1'b1;
					end else begin
						q_alloc_ff[p] <= 1'b0;
					end
				end else if (port_done[p]) begin
					q_alloc_ff[p] <= 1'b0;
					q_vld_ff[p] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// port sequencer strobes
	// ----------------------------------------
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			more[p] = !cur_hi_ff[p] && (q_mask_ff[p][7:4] != 4'h0);
			O_PB_REQ[p] = (pst_ff[p] == CPB_PS_ISSUE);
			port_done[p] = 1'b0;
			load_en[p] = 1'b0;
			load_hi[p] = cur_hi_ff[p];
			buf_we[p] = 1'b0;
			fill_done[p] = 1'b0;
			case (pst_ff[p])
				CPB_PS_FLUSH: begin
					load_en[p] = !rr_full_ff[p];
				end
				CPB_PS_ISSUE: begin
					if (I_PB_TIMEOUT[p]) begin
						port_done[p] = 1'b1;
					end else if (I_PB_GNT[p] && q_wr_ff[p]) begin
						load_en[p] = more[p];
						load_hi[p] = 1'b1;
						port_done[p] = !more[p];
					end
				end
				CPB_PS_WAIT: begin
					if (I_PB_TIMEOUT[p]) begin
						port_done[p] = 1'b1;
					end else if (I_PB_RDATA_VALID[p]) begin
						buf_we[p] = 1'b1;
						load_en[p] = more[p];
						load_hi[p] = 1'b1;
						port_done[p] = !more[p];
						fill_done[p] = !more[p];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// port sequencer state
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			pst_ff <= '{default: CPB_PS_IDLE};
			cur_hi_ff <= 2'b00;
			pref_inv_ff <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				pref_inv_ff[p] <= 1'b0;
				case (pst_ff[p])
					CPB_PS_IDLE: begin
						if (q_vld_ff[p]) begin
							pref_inv_ff[p] <= 1'b1;
							cur_hi_ff[p] <= first_hi(q_mask_ff[p]);
							pst_ff[p] <= CPB_PS_FLUSH;
						end
					end
					CPB_PS_FLUSH: begin
						if (load_en[p]) begin
							pst_ff[p] <= CPB_PS_ISSUE;
						end
					end
					CPB_PS_ISSUE: begin
						if (port_done[p]) begin
							pst_ff[p] <= CPB_PS_IDLE;
						end else if (I_PB_GNT[p] && !q_wr_ff[p]) begin
							pst_ff[p] <= CPB_PS_WAIT;
						end else if (load_en[p]) begin
							cur_hi_ff[p] <= 1'b1;
						end
					end
					CPB_PS_WAIT: begin
						if (port_done[p]) begin
							pst_ff[p] <= CPB_PS_IDLE;
						end else if (load_en[p]) begin
							cur_hi_ff[p] <= 1'b1;
							pst_ff[p] <= CPB_PS_ISSUE;
						end
					end
					default: begin
						pst_ff[p] <= CPB_PS_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// port bus outputs
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			out_addr_ff <= '{default: `CPB_RST_ADDR};
			out_wdata_ff <= '{default: `CPB_RST_LW};
			out_be_ff <= '{default: `CPB_RST_BE};
			out_wr_ff <= 2'b00;
			out_ist_ff <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (load_en[p]) begin
					out_addr_ff[p] <= {q_addr_ff[p][`CPB_QW_MSB:`CPB_QW_LSB], load_hi[p], 2'b00};
					out_be_ff[p] <= load_hi[p] ? q_mask_ff[p][7:4] : q_mask_ff[p][3:0];
					out_wdata_ff[p] <= load_hi[p] ? q_data_ff[p][63:32] : q_data_ff[p][31:0];
					out_wr_ff[p] <= q_wr_ff[p];
					out_ist_ff[p] <= q_ist_ff[p] && !q_wr_ff[p];
				end
			end
		end
	end

	assign O_PB_ADDR = out_addr_ff;
	assign O_PB_WDATA = out_wdata_ff;
	assign O_PB_BE = out_be_ff;
	assign O_PB_WR = out_wr_ff;
	assign O_PB_ISTREAM = out_ist_ff;
	assign O_PB_PREF_INV = pref_inv_ff;

	// ----------------------------------------
	// read return to the host bus
	// ----------------------------------------
	// fixed priority to the first port; a port cannot refill before draining
	assign rr_pick = !rr_full_ff[0];
	assign O_RR_REQ = (rs_ff == CPB_RS_IDLE) && (rr_full_ff != 2'b00);
	assign rr_take = O_RR_REQ && I_RR_GNT;

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			rs_ff <= CPB_RS_IDLE;
			rr_sel_ff <= 1'b0;
			tag_out_ff <= `CPB_RST_TAG;
		end else begin
			case (rs_ff)
				CPB_RS_IDLE: begin
					if (rr_take) begin
						rr_sel_ff <= rr_pick;
						tag_out_ff <= rr_tag_ff[rr_pick];
						rs_ff <= CPB_RS_READ;
					end
				end
				CPB_RS_READ: begin
					rs_ff <= CPB_RS_DRIVE;
				end
				default: begin
					rs_ff <= CPB_RS_IDLE;
				end
			endcase
		end
	end

	// set wins; in practice a full entry blocks its own refill
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			rr_full_ff <= 2'b00;
			rr_tag_ff <= '{default: `CPB_RST_TAG};
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (fill_done[p]) begin
					rr_full_ff[p] <= 1'b1;
					rr_tag_ff[p] <= q_addr_ff[p][`CPB_TAG_MSB:`CPB_TAG_LSB];
				end else if ((rs_ff == CPB_RS_DRIVE) && (rr_sel_ff == p[0])) begin
					rr_full_ff[p] <= 1'b0;
				end
			end
		end
	end

	assign O_RR_VALID = (rs_ff == CPB_RS_DRIVE);
	assign O_RR_TAG = tag_out_ff;
	assign O_RR_DATA = rd_data;

	cpb_ret_buf u_ret_buf (
		.i_clk(I_SYS_CLK),
		.i_resetn(I_RESETN),
		.i_wr_en(buf_we),
		.i_wr_hi(cur_hi_ff),
		.i_wr_data(I_PB_RDATA),
		.i_rd_en(rr_take),
		.i_rd_idx(rr_pick),
		.o_rd_data(rd_data)
	);
endmodule

// *** core/cpb_defines.svh ***
// Purpose: constants of the processor I/O port bridge
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes: address windows of the two port buses are local choices
//
// Summary of operation
// - write and write_and_release both become port writes
// - full quadword write goes as two longword grants
// - good-parity port address is acknowledged and queued
// - data parity good stores data, bad discards entry
// - foreign addresses ignored; address parity error flagged
// - prefetch buffer invalidated before port access
// - return buffer drained before any port write
// - write lower longword first unless its masks zero
// - instruction, data, other reads are port reads
// - reads queued without data, quadword split in two
// - return buffer drained before any port read
// - instruction read to I-stream, others to D-stream
// - read lower first unless masks zero, then upper
// - returned data buffered, then host return requested
// - after grant, return cycle drives buffered data
// - return tag taken from host address bits 4:3
// - port timeout ends transaction, nothing logged
`ifndef CPB_DEFINES_SVH
`define CPB_DEFINES_SVH

// ----------------------------------------
// address decode
// ----------------------------------------
`define CPB_PORT_SEL_MASK 32'hff00_0000
`define CPB_PORT0_BASE 32'h2000_0000
`define CPB_PORT1_BASE 32'h2100_0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define CPB_TAG_MSB 4
`define CPB_TAG_LSB 3
`define CPB_QW_MSB 31
`define CPB_QW_LSB 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define CPB_RST_ADDR 32'h0000_0000
`define CPB_RST_DATA 64'h0000_0000_0000_0000
`define CPB_RST_LW 32'h0000_0000
`define CPB_RST_MASK 8'h00
`define CPB_RST_BE 4'h0
`define CPB_RST_TAG 2'h0

`endif

// *** core/cpb_pkg.sv ***
// Purpose: types of the processor I/O port bridge
// Assumes: nothing beyond the defines header
// Notes: op codes on the host bus are a local encoding
package cpb_pkg;

// ----------------------------------------
// host bus operations
// ----------------------------------------
typedef enum logic [2:0] {
	CPB_OP_IDLE = 3'b000,
	CPB_OP_WRITE = 3'b001,
	CPB_OP_WRITE_REL = 3'b010,
	CPB_OP_INSTRUCTION_READ_OP = 3'b011,
	CPB_OP_DATA_READ_OP = 3'b100,
	CPB_OP_OTHER_READ_OP = 3'b101
} cpb_op_t;

// ----------------------------------------
// sequencer states
// ----------------------------------------
typedef enum logic [1:0] {
	CPB_PS_IDLE = 2'b00,
	CPB_PS_FLUSH = 2'b01,
	CPB_PS_ISSUE = 2'b10,
	CPB_PS_WAIT = 2'b11
} cpb_pst_t;

typedef enum logic [1:0] {
	CPB_RS_IDLE = 2'b00,
	CPB_RS_READ = 2'b01,
	CPB_RS_DRIVE = 2'b10
} cpb_rst_t;

endpackage

// *** core/cpb_ret_buf.sv ***
// Purpose: read return buffer, one quadword per port
// Assumes: each port writes only its own entry
// Notes: read data is registered, valid one cycle after i_rd_en
`include "cpb_defines.svh"
module cpb_ret_buf (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_wr_en,
	input wire logic [1:0] i_wr_hi,
	input wire logic [1:0][31:0] i_wr_data,
	input wire logic i_rd_en,
	input wire logic i_rd_idx,
	output logic [63:0] o_rd_data
);
	logic [63:0] mem [2];

	// ----------------------------------------
	// write lanes
	// ----------------------------------------
	// no reset on storage; entries are read only after being filled
	always_ff @(posedge i_clk) begin
		for (int p = 0; p < 2; p++) begin
			if (i_wr_en[p]) begin
				if (i_wr_hi[p]) begin
					mem[p][63:32] <= i_wr_data[p];
				end else begin
					mem[p][31:0] <= i_wr_data[p];
				end
			end
		end
	end

	// ----------------------------------------
	// registered read
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_rd_data <= `CPB_RST_DATA;
		end else if (i_rd_en) begin
			o_rd_data <= mem[i_rd_idx];
		end
	end
endmodule

// *** verification/cpb_bridge_sva.sv ***
// Purpose: port-level checks of the I/O port bridge
// Assumes: one clock domain, reset active low
// Notes: return timing follows the two-cycle grant walk
`include "cpb_defines.svh"
module cpb_bridge_sva
	import cpb_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	input wire logic I_HB_ADDR_VALID,
	input wire cpb_pkg::cpb_op_t I_HB_OP,
	input wire logic [31:0] I_HB_ADDR,
	input wire logic I_HB_ADDR_PAR,
	input wire logic I_HB_DATA_VALID,
	input wire logic [63:0] I_HB_DATA,
	input wire logic I_HB_DATA_PAR,
	input wire logic O_HB_ACK,
	input wire logic O_SOFT_ERR_REQ,
	input wire logic O_BUS_PAR_ERR,
	input wire logic O_RR_REQ,
	input wire logic I_RR_GNT,
	input wire logic O_RR_VALID,
	input wire logic [1:0] O_PB_REQ,
	input wire logic [1:0] O_PB_PREF_INV,
	input wire logic [1:0] I_PB_TIMEOUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic in_win;
	logic a_bad;
	assign in_win = (I_HB_ADDR & `CPB_PORT_SEL_MASK) == `CPB_PORT0_BASE
		|| (I_HB_ADDR & `CPB_PORT_SEL_MASK) == `CPB_PORT1_BASE;
	assign a_bad = ^{I_HB_ADDR, I_HB_ADDR_PAR};
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);
	// ----------
	// checks
	// ----------
	sequence s_wr_ack;
		O_HB_ACK && (I_HB_OP == CPB_OP_WRITE || I_HB_OP == CPB_OP_WRITE_REL);
	endsequence
	sequence s_bad_data;
		!I_HB_DATA_VALID || ^{I_HB_DATA, I_HB_DATA_PAR};
	endsequence
	sequence s_rr_take;
		O_RR_REQ && I_RR_GNT;
	endsequence
	// an empty return buffer gives one quiet cycle; a held return drain stretches it
	property p_inv_first(inv, req);
		inv |-> !req ##[1:40] req;
	endproperty
	chk_ack_cause: assert property (O_HB_ACK |-> I_HB_ADDR_VALID && in_win && !a_bad)
		else $error("ack without clean port address");
	chk_addr_parity: assert property (I_HB_ADDR_VALID && a_bad
		|-> !O_HB_ACK ##1 O_SOFT_ERR_REQ && O_BUS_PAR_ERR) else $error("address parity missed");
	chk_foreign_quiet: assert property (I_HB_ADDR_VALID && !in_win && !a_bad
		&& !$past(O_HB_ACK) |=> !O_SOFT_ERR_REQ) else $error("foreign address reacted");
	chk_data_parity: assert property (s_wr_ack ##1 s_bad_data |=> O_SOFT_ERR_REQ)
		else $error("bad write data not flagged");
	chk_rr_timing: assert property (s_rr_take |=> !O_RR_REQ && !O_RR_VALID ##1 O_RR_VALID)
		else $error("return cycle late or early");
	chk_rr_cause: assert property (O_RR_VALID |-> $past(I_RR_GNT, 2) && $past(O_RR_REQ, 2))
		else $error("return cycle without grant");
	chk_inv_port0: assert property (p_inv_first(O_PB_PREF_INV[0], O_PB_REQ[0]))
		else $error("port 0 invalidate order");
	chk_inv_port1: assert property (p_inv_first(O_PB_PREF_INV[1], O_PB_REQ[1]))
		else $error("port 1 invalidate order");
	chk_timeout_silent: assert property (I_PB_TIMEOUT != 2'b00 && !I_HB_ADDR_VALID
		&& !$past(O_HB_ACK) |=> !O_SOFT_ERR_REQ) else $error("timeout raised an error");
endmodule
bind cpb_bridge cpb_bridge_sva cpb_bridge_sva_inst (.*);

// *** verification/cpb_port_model.sv ***
// Purpose: one port bus device facing the bridge
// Assumes: answers change just after the rising edge
// Notes: data lines toggle whenever no read answer is on them
module cpb_port_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [31:0] i_addr,
	input wire logic i_slow,
	input wire logic i_mute,
	output logic o_gnt,
	output logic o_rvld,
	output logic [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff;
	logic [3:0] dly_ff;
	logic pend_ff;
	logic [31:0] radr_ff;
	// ----------
	// grant and answer
	// ----------
	always_ff @(posedge i_clk) begin
		if (!i_resetn || o_gnt || !i_req) begin
			o_gnt <= 1'b0;
			cnt_ff <= 4'h0;
		end else begin
			o_gnt <= cnt_ff >= (i_slow ? 4'h4 : 4'h0);
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		o_rvld <= 1'b0;
		o_rdata <= ~o_rdata;
		if (!i_resetn) begin
			pend_ff <= 1'b0;
			o_rdata <= 32'h0;
		end else if (o_gnt && i_req && !i_wr) begin
			pend_ff <= 1'b1;
			radr_ff <= i_addr;
			dly_ff <= i_slow ? 4'h6 : 4'h1;
		end else if (i_mute) begin
			pend_ff <= 1'b0;
		end else if (pend_ff && dly_ff == 4'h1) begin
			o_rvld <= 1'b1;
			o_rdata <= ~radr_ff;
			pend_ff <= 1'b0;
		end else if (pend_ff) begin
			dly_ff <= dly_ff - 4'h1;
		end
	end
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench of the I/O port bridge
// Assumes: inputs driven on the falling edge
// Notes: port 1 device answers slowly, host grant stalls two cycles
`include "cpb_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cpb_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hv = 1'b0;
	cpb_op_t hop = CPB_OP_IDLE;
	logic [31:0] ha = 32'h0;
	logic hap = 1'b0;
	logic [7:0] hm = 8'h0;
	logic hdv = 1'b0;
	logic [63:0] hd = 64'h0;
	logic hdp = 1'b0;
	logic clr = 1'b0;
	logic rgnt = 1'b0;
	logic hold = 1'b0;
	logic [2:0] rcnt = 3'h0;
	logic [1:0] tmo = 2'h0;
	logic [1:0] mute = 2'h0;
	logic ack, serr, perr, rreq, rv;
	logic [1:0] rtag, preq, gnt, pwr, pis, inv, rvld;
	logic [63:0] rd;
	logic [1:0][31:0] pa, pwd, prd;
	logic [1:0][3:0] pbe;
	logic [69:0] lw_q[2][$];
	logic [65:0] rr_q[$];
	int err_total = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	cpb_bridge cpb_bridge_inst (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_HB_ADDR_VALID(hv),
		.I_HB_OP(hop), .I_HB_ADDR(ha), .I_HB_ADDR_PAR(hap), .I_HB_MASK(hm),
		.I_HB_DATA_VALID(hdv), .I_HB_DATA(hd), .I_HB_DATA_PAR(hdp), .O_HB_ACK(ack),
		.O_SOFT_ERR_REQ(serr), .O_BUS_PAR_ERR(perr), .I_BUS_PAR_ERR_CLR(clr),
		.O_RR_REQ(rreq), .I_RR_GNT(rgnt), .O_RR_VALID(rv), .O_RR_TAG(rtag), .O_RR_DATA(rd),
		.O_PB_REQ(preq), .I_PB_GNT(gnt), .O_PB_WR(pwr), .O_PB_ISTREAM(pis), .O_PB_ADDR(pa),
		.O_PB_WDATA(pwd), .O_PB_BE(pbe), .O_PB_PREF_INV(inv), .I_PB_RDATA_VALID(rvld),
		.I_PB_RDATA(prd), .I_PB_TIMEOUT(tmo));
	for (genvar p = 0; p < 2; p++) begin : g_dev
		cpb_port_model cpb_port_model_inst (.i_clk(clk), .i_resetn(rstn), .i_req(preq[p]),
			.i_wr(pwr[p]), .i_addr(pa[p]), .i_slow(p == 1), .i_mute(mute[p]),
			.o_gnt(gnt[p]), .o_rvld(rvld[p]), .o_rdata(prd[p]));
	end
	// ----------
	// monitors and host arbiter
	// ----------
	always @(posedge clk) begin
		for (int p = 0; p < 2; p++)
			if (preq[p] && gnt[p]) lw_q[p].push_back({pwr[p], pis[p], pa[p], pbe[p], pwd[p]});
		if (rv) rr_q.push_back({rtag, rd});
	end
	always @(negedge clk) begin
		rgnt <= rreq && rcnt == 3'h2 && !hold;
		rcnt <= (rreq && !rgnt && !hold) ? rcnt + 3'h1 : 3'h0;
	end
	// ----------
	// shared tasks
	// ----------
	task automatic finish_test;
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp_vec(input string n, input logic [71:0] e, input logic [71:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_bit(input string n, input logic e, input logic g);
		cmp_vec(n, 72'(e), 72'(g));
	endtask
	task automatic wait_n(input int p, input int n);
		int k;
		for (k = 0; k < 400 && (p < 2 ? lw_q[p].size() : rr_q.size()) < n; k++) @(negedge clk);
		if (k == 400) begin
			cmp_vec("transfer count", 72'(n), 72'h0);
			finish_test();
		end
	endtask
	task automatic quiet;
		repeat (40) @(negedge clk);
		cmp_vec("extra traffic", 72'h0, 72'(lw_q[0].size() + lw_q[1].size() + rr_q.size()));
	endtask
	task automatic chk_lw(input int p, input logic [69:0] e, input logic [69:0] m);
		logic [69:0] g;
		g = lw_q[p].pop_front();
		cmp_vec("port longword", 72'(e & m), 72'(g & m));
	endtask
	task automatic host_req(input cpb_op_t op, input logic [31:0] a, input logic [7:0] m,
		input logic [63:0] d, input logic [1:0] bad, input logic ea, output logic [1:0] se);
		@(negedge clk);
		hv = 1'b1;
		hop = op;
		ha = a;
		hap = ^a ^ bad[1];
		hm = m;
		#1 cmp_bit("ack", ea, ack);
		@(negedge clk);
		se[1] = serr;
		hv = 1'b0;
		hop = CPB_OP_IDLE;
		hdv = ea && (op == CPB_OP_WRITE || op == CPB_OP_WRITE_REL);
		hd = d;
		hdp = ^d ^ bad[0];
		@(negedge clk);
		se[0] = serr;
		hdv = 1'b0;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_xfer(input logic rd_mode);
		cpb_op_t ops[4];
		logic [7:0] ms[4] = '{8'hff, 8'hf0, 8'h00, 8'h0f};
		logic [31:0] a;
		logic [63:0] d, dm;
		logic [65:0] r;
		logic [1:0] se;
		logic lo, hi, is;
		if (rd_mode) ops = '{CPB_OP_INSTRUCTION_READ_OP, CPB_OP_DATA_READ_OP, CPB_OP_OTHER_READ_OP, CPB_OP_INSTRUCTION_READ_OP};
		else ops = '{CPB_OP_WRITE, CPB_OP_WRITE_REL, CPB_OP_WRITE, CPB_OP_WRITE_REL};
		for (int i = 0; i < 4; i++) begin
			a = (i % 2 ? `CPB_PORT1_BASE : `CPB_PORT0_BASE) + 32'(i * 8);
			d = {32'hc0de_0000 + 32'(i), 32'h0bad_0000 + 32'(i)};
			lo = ms[i][3:0] != 4'h0;
			hi = ms[i][7:4] != 4'h0 || !lo;
			is = ops[i] == CPB_OP_INSTRUCTION_READ_OP;
			dm = rd_mode ? 64'h0 : 64'hffff_ffff;
			host_req(ops[i], a, ms[i], d, 2'b00, 1'b1, se);
			wait_n(i % 2, int'(lo) + int'(hi));
			if (lo) chk_lw(i % 2,
				{!rd_mode, is, a[31:3], 3'h0, ms[i][3:0], d[31:0]},
				{38'h3f_ffff_ffff, dm[31:0]});
			if (hi) chk_lw(i % 2,
				{!rd_mode, is, a[31:3], 3'h4, ms[i][7:4], d[63:32]},
				{38'h3f_ffff_ffff, dm[31:0]});
			if (rd_mode) begin
				wait_n(2, 1);
				r = rr_q.pop_front();
				cmp_vec("return tag", 72'(i), 72'(r[65:64]));
				dm = {{32{hi}}, {32{lo}}};
				cmp_vec("return data",
					72'({~{a[31:3], 3'h4}, ~{a[31:3], 3'h0}} & dm), 72'(r[63:0] & dm));
			end
		end
		quiet();
	endtask
	task automatic t_errors;
		logic [1:0] se;
		host_req(CPB_OP_WRITE, `CPB_PORT0_BASE, 8'hff, 64'h0, 2'b10, 1'b0, se);
		cmp_bit("soft error", 1'b1, se[1]);
		cmp_bit("parity status", 1'b1, perr);
		@(negedge clk) clr = 1'b1;
		@(negedge clk) clr = 1'b0;
		cmp_bit("parity status", 1'b0, perr);
		host_req(CPB_OP_DATA_READ_OP, 32'h3000_0000, 8'hff, 64'h0, 2'b10, 1'b0, se);
		cmp_bit("soft error", 1'b1, se[1]);
		host_req(CPB_OP_DATA_READ_OP, 32'h3000_0000, 8'hff, 64'h0, 2'b00, 1'b0, se);
		cmp_bit("soft error", 1'b0, se[1]);
		host_req(CPB_OP_WRITE, `CPB_PORT1_BASE, 8'hff, 64'h1, 2'b01, 1'b1, se);
		cmp_vec("soft error", 72'h1, 72'(se));
		quiet();
	endtask
	task automatic t_timeout;
		logic [1:0] se;
		logic [65:0] r;
		mute = 2'b01;
		host_req(CPB_OP_DATA_READ_OP, `CPB_PORT0_BASE + 32'h18, 8'hff, 64'h0, 2'b00, 1'b1, se);
		wait_n(0, 1);
		void'(lw_q[0].pop_front());
		@(negedge clk) tmo = 2'b01;
		@(negedge clk) tmo = 2'b00;
		mute = 2'b00;
		quiet();
		host_req(CPB_OP_DATA_READ_OP, `CPB_PORT0_BASE, 8'h0f, 64'h0, 2'b00, 1'b1, se);
		wait_n(0, 1);
		chk_lw(0, {2'b00, `CPB_PORT0_BASE, 4'hf, 32'h0},
			{38'h3f_ffff_ffff, 32'h0});
		wait_n(2, 1);
		r = rr_q.pop_front();
		cmp_vec("return after timeout", 72'({2'h0, ~`CPB_PORT0_BASE}),
			72'({r[65:64], r[31:0]}));
	endtask
	// host grant held off so a full return buffer must block the next write
	task automatic t_flush;
		logic [1:0] se;
		logic [65:0] r;
		hold = 1'b1;
		host_req(CPB_OP_DATA_READ_OP, `CPB_PORT0_BASE + 32'h8, 8'h0f, 64'h0, 2'b00, 1'b1, se);
		wait_n(0, 1);
		chk_lw(0, {2'b00, `CPB_PORT0_BASE + 32'h8, 4'hf, 32'h0},
			{38'h3f_ffff_ffff, 32'h0});
		repeat (4) @(negedge clk);
		host_req(CPB_OP_WRITE, `CPB_PORT0_BASE, 8'h0f, 64'h5, 2'b00, 1'b1, se);
		repeat (12) @(negedge clk);
		cmp_vec("write before flush", 72'h0, 72'(lw_q[0].size()));
		hold = 1'b0;
		wait_n(2, 1);
		r = rr_q.pop_front();
		cmp_vec("flushed return", 72'({2'h1, ~(`CPB_PORT0_BASE + 32'h8)}),
			72'({r[65:64], r[31:0]}));
		wait_n(0, 1);
		chk_lw(0, {2'b10, `CPB_PORT0_BASE, 4'hf, 32'h5},
			{38'h3f_ffff_ffff, 32'hffff_ffff});
		quiet();
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		t_xfer(1'b0);
		t_xfer(1'b1);
		t_errors();
		t_timeout();
		t_flush();
		finish_test();
	end
endmodule
